// File: core/ebm_bus.sv
// external multiplexed bus interface with internal RAM and map decode
`timescale 1ns/10ps
module ebm_bus (
	input wire logic CLK,
	input wire logic RST,
	// core request side
	input wire logic REQ,
	input wire logic REQ_WRITE,
	input wire logic REQ_WORD,
	input wire logic [23:0] REQ_ADDR,
	input wire logic [15:0] REQ_WDATA,
	input wire logic [15:0] DIRECT_WINDOW_BASE,
	output logic REQ_DONE,
	output logic [15:0] REQ_RDATA,
	output logic REQ_IN_WINDOW,
	output logic REQ_VECTOR,
	output logic REQ_SFR,
	output logic [7:0] SFR_ADDR,
	output logic SFR_WRITE,
	output logic [15:0] SFR_WDATA,
	input wire logic [15:0] SFR_RDATA,
	// pins
	input wire logic BUS_WIDTH_8,
	input wire logic READY_N,
	input wire logic HOLD_REQ_N,
	output logic BUS_RELEASE_GRANT,
	output logic CLK_HALF,
	output logic ACCESS_N,
	output logic ADDR_LATCH,
	output logic READ_WRITE,
	output logic UPPER_LANE_ENABLE_N,
	output logic [7:0] ADDR_LOW,
	input wire logic [7:0] MID_IN,
	output logic [7:0] MID_OUT,
	output logic MID_OE,
	input wire logic [7:0] HIGH_IN,
	output logic [7:0] HIGH_OUT,
	output logic HIGH_OE
);
	// ---------------------------------------------------------------
	// decode
	// ---------------------------------------------------------------
	ebm_pkg::ebm_target_e target;
	logic is_vector;
	logic in_window;
	ebm_decode u_decode (
		.addr(REQ_ADDR),
		.win_base(DIRECT_WINDOW_BASE),
		.target(target),
		.is_vector(is_vector),
		.in_window(in_window)
	);
	// ---------------------------------------------------------------
	// internal RAM
	// ---------------------------------------------------------------
	logic ram_we;
	logic [1:0] ram_be;
	logic [15:0] ram_rdata;
	logic [15:0] ram_off;
	logic [ebm_pkg::RAM_AW-1:0] ram_addr;
	// word index within ram area, byte address offset removed
	assign ram_off = REQ_ADDR[15:0] - ebm_pkg::RAM_FIRST;
	assign ram_addr = ram_off[ebm_pkg::RAM_AW:1];
	ebm_ram #(
		.WORDS(ebm_pkg::RAM_WORDS),
		.AW(ebm_pkg::RAM_AW)
	) u_ram (
		.clk(CLK),
		.we(ram_we),
		.be(ram_be),
		.addr(ram_addr),
		.wdata(REQ_WDATA),
		.rdata(ram_rdata)
	);
	// ---------------------------------------------------------------
	// clock output divider
	// ---------------------------------------------------------------
	logic clk_half;
	logic next_clk_half;
	// R1 divide by two
	always_comb begin
		next_clk_half = ~clk_half;
	end
	always_ff @(posedge CLK) begin
		if (RST) begin
			clk_half <= 1'b0;
		end else begin
			clk_half <= next_clk_half;
		end
	end
	// ---------------------------------------------------------------
	// bus cycle sequencer
	// ---------------------------------------------------------------
	ebm_pkg::ebm_state_e state, next_state;
	logic [23:0] addr_q, next_addr_q;
	logic [15:0] wdata_q, next_wdata_q;
	logic write_q, next_write_q;
	logic word_q, next_word_q;
	logic half_q, next_half_q; // second byte in 8-bit mode
	logic [15:0] rdata, next_rdata;
	logic done, next_done;
	logic grant, next_grant;
	logic access_n, next_access_n;
	logic latch, next_latch;
	logic rw, next_rw;
	logic ule_n, next_ule_n;
	logic [7:0] addr_low, next_addr_low;
	logic [7:0] mid_out, next_mid_out;
	logic mid_oe, next_mid_oe;
	logic [7:0] high_out, next_high_out;
	logic high_oe, next_high_oe;
	logic sfr, next_sfr;
	logic sfr_we, next_sfr_we;
	logic win, next_win;
	logic vec, next_vec;
	logic ram_rd, next_ram_rd; // ram read pending
	logic [23:0] cur_addr;
	// address of the current byte or word on the bus
	// R11 linear 24-bit space
	assign cur_addr = addr_q + {23'h000000, half_q};
	always_comb begin
		next_state = state;
		next_addr_q = addr_q;
		next_wdata_q = wdata_q;
		next_write_q = write_q;
		next_word_q = word_q;
		next_half_q = half_q;
		next_rdata = rdata;
		next_done = 1'b0;
		next_grant = grant;
		next_access_n = access_n;
		next_latch = 1'b0;
		next_rw = rw;
		next_ule_n = ule_n;
		next_addr_low = addr_low;
		next_mid_out = mid_out;
		next_mid_oe = mid_oe;
		next_high_out = high_out;
		next_high_oe = high_oe;
		next_sfr = 1'b0;
		next_sfr_we = 1'b0;
		next_win = win;
		next_vec = vec;
		next_ram_rd = 1'b0;
		ram_we = 1'b0;
		ram_be = 2'b00;
		// completion of a registered ram read
		if (ram_rd) begin
			next_rdata = ram_rdata;
			next_done = 1'b1;
		end
		unique case (state)
			ebm_pkg::EBM_IDLE: begin
				// R3 hold has priority over a new cycle
				if (!HOLD_REQ_N) begin
					next_state = ebm_pkg::EBM_HOLD;
					// R4 grant shows hold
					next_grant = 1'b1;
					next_mid_oe = 1'b0;
					next_high_oe = 1'b0;
				end else if (REQ && !ram_rd) begin
					next_addr_q = REQ_ADDR;
					next_wdata_q = REQ_WDATA;
					next_write_q = REQ_WRITE;
					next_word_q = REQ_WORD;
					next_half_q = 1'b0;
					next_win = in_window;
					next_vec = is_vector;
					if (target == ebm_pkg::EBM_T_RAM) begin
						// R15 internal ram, write done in one cycle, registered read done in two
						ram_we = REQ_WRITE;
						ram_be = REQ_WORD ? 2'b11 : {REQ_ADDR[0], ~REQ_ADDR[0]};
						next_ram_rd = ~REQ_WRITE;
						next_done = REQ_WRITE;
					end else if (target == ebm_pkg::EBM_T_SFR) begin
						// R16 peripheral register access
						next_sfr = 1'b1;
						next_sfr_we = REQ_WRITE;
						next_rdata = SFR_RDATA;
						next_done = 1'b1;
					end else begin
						// R20 external cycle starts
						next_state = ebm_pkg::EBM_ADDR;
					end
				end
			end
			ebm_pkg::EBM_ADDR: begin
				// R7 latch strobe with address on pins
				next_latch = 1'b1;
				next_access_n = 1'b1;
				// R5 direction
				next_rw = ~write_q;
				// R6 odd address, or word in 16-bit mode, wants upper lane
				next_ule_n = ~(cur_addr[0] | (word_q & ~BUS_WIDTH_8));
				next_addr_low = cur_addr[7:0];
				// R8 R9 middle lines carry address
				next_mid_out = cur_addr[15:8];
				next_mid_oe = 1'b1;
				// R10 upper lines carry bank byte
				next_high_out = cur_addr[23:16];
				next_high_oe = 1'b1;
				next_state = ebm_pkg::EBM_DATA;
			end
			ebm_pkg::EBM_DATA: begin
				// R18 transfer window, strobe low
				next_access_n = 1'b0;
				next_mid_oe = write_q & ~BUS_WIDTH_8;
				next_high_oe = write_q;
				// R10 low data byte or selected byte in 8-bit mode
				next_high_out = (BUS_WIDTH_8 && half_q) ? wdata_q[15:8] : wdata_q[7:0];
				// R8 high data only in 16-bit mode; R9 never in 8-bit
				next_mid_out = wdata_q[15:8];
				next_state = ebm_pkg::EBM_DONE;
			end
			ebm_pkg::EBM_DONE: begin
				// R2 ready low stretches the cycle
				if (READY_N) begin
					next_access_n = 1'b1;
					next_mid_oe = 1'b0;
					next_high_oe = 1'b0;
					if (BUS_WIDTH_8) begin
						if (half_q) begin
							next_rdata[15:8] = HIGH_IN;
						end else begin
							next_rdata[7:0] = HIGH_IN;
						end
					end else begin
						next_rdata = {MID_IN, HIGH_IN};
					end
					// 8-bit bus splits a word into two byte cycles
					if (BUS_WIDTH_8 && word_q && !half_q) begin
						next_half_q = 1'b1;
						next_state = ebm_pkg::EBM_ADDR;
					end else begin
						next_done = 1'b1;
						next_state = ebm_pkg::EBM_IDLE;
					end
				end
			end
			ebm_pkg::EBM_HOLD: begin
				// R3 stay released while request held low
				if (HOLD_REQ_N) begin
					next_grant = 1'b0;
					next_state = ebm_pkg::EBM_IDLE;
				end
			end
			default: begin
				next_state = ebm_pkg::EBM_IDLE;
			end
		endcase
	end
	// registers of the sequencer
	always_ff @(posedge CLK) begin
		if (RST) begin
			state <= ebm_pkg::EBM_IDLE;
			addr_q <= 24'h000000;
			wdata_q <= 16'h0000;
			write_q <= 1'b0;
			word_q <= 1'b0;
			half_q <= 1'b0;
			rdata <= 16'h0000;
			done <= 1'b0;
			grant <= 1'b0;
			access_n <= 1'b1;
			latch <= 1'b0;
			rw <= 1'b1;
			ule_n <= 1'b1;
			addr_low <= 8'h00;
			mid_out <= 8'h00;
			mid_oe <= 1'b0;
			high_out <= 8'h00;
			high_oe <= 1'b0;
			sfr <= 1'b0;
			sfr_we <= 1'b0;
			win <= 1'b0;
			vec <= 1'b0;
			ram_rd <= 1'b0;
		end else begin
			state <= next_state;
			addr_q <= next_addr_q;
			wdata_q <= next_wdata_q;
			write_q <= next_write_q;
			word_q <= next_word_q;
			half_q <= next_half_q;
			rdata <= next_rdata;
			done <= next_done;
			grant <= next_grant;
			access_n <= next_access_n;
			latch <= next_latch;
			rw <= next_rw;
			ule_n <= next_ule_n;
			addr_low <= next_addr_low;
			mid_out <= next_mid_out;
			mid_oe <= next_mid_oe;
			high_out <= next_high_out;
			high_oe <= next_high_oe;
			sfr <= next_sfr;
			sfr_we <= next_sfr_we;
			win <= next_win;
			vec <= next_vec;
			ram_rd <= next_ram_rd;
		end
	end
	// ---------------------------------------------------------------
	// outputs, all from flip-flops
	// ---------------------------------------------------------------
	assign CLK_HALF = clk_half;
	assign BUS_RELEASE_GRANT = grant;
	assign ACCESS_N = access_n;
	assign ADDR_LATCH = latch;
	assign READ_WRITE = rw;
	assign UPPER_LANE_ENABLE_N = ule_n;
	assign ADDR_LOW = addr_low;
	assign MID_OUT = mid_out;
	assign MID_OE = mid_oe;
	assign HIGH_OUT = high_out;
	assign HIGH_OE = high_oe;
	assign REQ_DONE = done;
	assign REQ_RDATA = rdata;
	assign REQ_IN_WINDOW = win;
	assign REQ_VECTOR = vec;
	assign REQ_SFR = sfr;
	assign SFR_WRITE = sfr_we;
	assign SFR_ADDR = addr_q[7:0];
	assign SFR_WDATA = wdata_q;
endmodule

// File: core/ebm_decode.sv
// address decoder: bank zero regions and direct window
`timescale 1ns/10ps
module ebm_decode (
	input wire logic [23:0] addr,
	input wire logic [15:0] win_base,
	output ebm_pkg::ebm_target_e target,
	output logic is_vector,
	output logic in_window
);
	logic [7:0] bank;
	logic [15:0] off;
	logic [16:0] win_end;
	// R12 bank split
	assign bank = addr[23:16];
	assign off = addr[15:0];
	assign win_end = {1'b0, win_base} + {1'b0, ebm_pkg::WIN_SIZE_M1};
	// decode of region; only bank zero holds internals
	always_comb begin
		target = ebm_pkg::EBM_T_EXT;
		// R13 bank zero only
		if (bank == ebm_pkg::BANK_ZERO) begin
			// R16 register area
			if (off <= ebm_pkg::SFR_LAST) begin
				target = ebm_pkg::EBM_T_SFR;
			// R15 ram area
			end else if (off >= ebm_pkg::RAM_FIRST && off <= ebm_pkg::RAM_LAST) begin
				target = ebm_pkg::EBM_T_RAM;
			end
		end
	end
	// R14 vector area flag
	assign is_vector = (bank == ebm_pkg::BANK_ZERO) && (off >= ebm_pkg::VEC_FIRST);
	// R17 window hit, clipped at bank end
	assign in_window = (bank == ebm_pkg::BANK_ZERO) && (off >= win_base) && ({1'b0, off} <= win_end);
endmodule

// File: core/ebm_pkg.sv
// constants and types shared by the external bus interface design
//
// Summary of operation
// R1 - clock output is oscillator divided by two
// R2 - ready low freezes the bus cycle
// R3 - hold request low releases the bus
// R4 - hold grant output shows hold state
// R5 - read/write high on read, low write
// R6 - upper lane enable low on odd address
// R7 - latch strobe marks address phase
// R8 - 16-bit mode: middle lines address, then data
// R9 - 8-bit mode: middle lines address only
// R10 - upper lines address high, then low data
// R11 - 16 MB linear space from zero
// R12 - 64 KB banks, bank is top byte
// R13 - internal RAM and registers only bank zero
// R14 - bank zero FFD6 to FFFF vectors
// R15 - internal RAM at 80 through 87F
// R16 - peripheral registers at 0 through 7F
// R17 - 256-byte direct window at base register
// R18 - external transfers only while strobe low
// R19 - board ties width pin low for 16-bit
// R20 - undecoded addresses go to external bus
package ebm_pkg;
	// ---------------------------------------------------------------
	// address map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam logic [7:0] BANK_ZERO = 8'h00;
	localparam logic [15:0] SFR_LAST = 16'h007F;
	localparam logic [15:0] RAM_FIRST = 16'h0080;
	localparam logic [15:0] RAM_LAST = 16'h087F;
	localparam logic [15:0] VEC_FIRST = 16'hFFD6;
	localparam logic [15:0] WIN_SIZE_M1 = 16'h00FF;
	localparam int RAM_WORDS = 1024;
	localparam int RAM_AW = 10;
	// ---------------------------------------------------------------
	// bus cycle states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		EBM_IDLE = 3'b000,
		EBM_ADDR = 3'b001,
		EBM_DATA = 3'b010,
		EBM_DONE = 3'b011,
		EBM_HOLD = 3'b100
	} ebm_state_e;
	// target of a decoded access
	typedef enum logic [1:0] {
		EBM_T_SFR = 2'b00,
		EBM_T_RAM = 2'b01,
		EBM_T_EXT = 2'b10
	} ebm_target_e;
endpackage

// File: core/ebm_ram.sv
// internal 2048-byte RAM as 1024 words with byte lanes
`timescale 1ns/10ps
module ebm_ram #(
	parameter int WORDS = 1024,
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [1:0] be,
	input wire logic [AW-1:0] addr,
	input wire logic [15:0] wdata,
	output logic [15:0] rdata
);
	// storage array, no reset needed
	logic [15:0] mem [WORDS];
	// registered read, byte-lane write
	always_ff @(posedge clk) begin
		if (we && be[0]) begin
			mem[addr][7:0] <= wdata[7:0];
		end
		if (we && be[1]) begin
			mem[addr][15:8] <= wdata[15:8];
		end
		rdata <= mem[addr];
	end
endmodule

// File: dv/ebm_bus_chk.sv
// assertions on the pins of the external bus block
`timescale 1ns/10ps
module ebm_bus_chk (
	input wire logic CLK,
	input wire logic RST,
	input wire logic READY_N,
	input wire logic HOLD_REQ_N,
	input wire logic BUS_WIDTH_8,
	input wire logic BUS_RELEASE_GRANT,
	input wire logic CLK_HALF,
	input wire logic ACCESS_N,
	input wire logic ADDR_LATCH,
	input wire logic READ_WRITE,
	input wire logic MID_OE,
	input wire logic HIGH_OE
);
	// ----
	// one domain, sync reset
	// ----
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	property p_half;
		1 |=> CLK_HALF != $past(CLK_HALF);
	endproperty
	a_half: assert property (p_half) else $error("half clock stuck");
	property p_wait;
		!ACCESS_N && !READY_N |=> !ACCESS_N;
	endproperty
	a_wait: assert property (p_wait) else $error("strobe ended in wait");
	property p_hold;
		BUS_RELEASE_GRANT && !HOLD_REQ_N |=> BUS_RELEASE_GRANT;
	endproperty
	a_hold: assert property (p_hold) else $error("grant dropped early");
	property p_free;
		BUS_RELEASE_GRANT |-> ACCESS_N && !MID_OE && !HIGH_OE;
	endproperty
	a_free: assert property (p_free) else $error("bus driven in hold");
	property p_drop;
		BUS_RELEASE_GRANT && HOLD_REQ_N |=> !BUS_RELEASE_GRANT;
	endproperty
	a_drop: assert property (p_drop) else $error("grant kept");
	property p_rd;
		!ACCESS_N && READ_WRITE |-> !MID_OE && !HIGH_OE;
	endproperty
	a_rd: assert property (p_rd) else $error("lines driven on read");
	property p_wr;
		!ACCESS_N && !READ_WRITE |-> HIGH_OE;
	endproperty
	a_wr: assert property (p_wr) else $error("no write data");
	property p_latch;
		ADDR_LATCH |-> ACCESS_N && HIGH_OE ##1 !ACCESS_N;
	endproperty
	a_latch: assert property (p_latch) else $error("latch phase wrong");
	property p_w8;
		BUS_WIDTH_8 && !ACCESS_N |-> !MID_OE;
	endproperty
	a_w8: assert property (p_w8) else $error("middle lines drive data");
endmodule

bind ebm_bus ebm_bus_chk i_ebm_bus_chk (.CLK(CLK), .RST(RST), .READY_N(READY_N),
	.HOLD_REQ_N(HOLD_REQ_N), .BUS_WIDTH_8(BUS_WIDTH_8), .BUS_RELEASE_GRANT(BUS_RELEASE_GRANT),
	.CLK_HALF(CLK_HALF), .ACCESS_N(ACCESS_N), .ADDR_LATCH(ADDR_LATCH), .READ_WRITE(READ_WRITE),
	.MID_OE(MID_OE), .HIGH_OE(HIGH_OE));

// File: dv/ebm_ext_mem.sv
// behavioural external memory on the multiplexed bus
`timescale 1ns/10ps
module ebm_ext_mem (
	input wire logic clk,
	input wire logic width_8,
	input wire logic [3:0] waits,
	input wire logic access_n,
	input wire logic addr_latch,
	input wire logic read_write,
	input wire logic upper_lane_enable_n,
	input wire logic [7:0] addr_low,
	input wire logic [7:0] mid_out,
	input wire logic [7:0] high_out,
	output logic [7:0] mid_in,
	output logic [7:0] high_in,
	output logic ready_n
);
	logic [7:0] mem [logic [23:0]]; // sparse byte store
	logic [23:0] a = 24'h000000; // latched address
	int wr_n = 0; // write count, wakes the read path
	logic [3:0] wc = 4'h0; // wait cycles used
	logic [7:0] lh = 8'h00; // last driven bytes
	logic [7:0] lm = 8'h00;
	// stamp is only there so the read path re-evaluates after every write
	function automatic logic [7:0] rd(input logic [23:0] x, input int stamp);
		return mem.exists(x) ? mem[x] : 8'hEE;
	endfunction
	wire drv = !access_n && read_write;
	wire [7:0] hv = width_8 ? rd(a, wr_n) : rd({a[23:1], 1'b0}, wr_n);
	wire [7:0] mv = rd({a[23:1], 1'b1}, wr_n);
	// stretch strobe by set wait count
	assign ready_n = access_n || (wc >= waits);
	// released lines show the inverse, not stale data
	assign high_in = drv ? hv : ~lh;
	assign mid_in = drv ? mv : ~lm;
	// address on latch, data only while strobe low
	always @(posedge clk) begin
		if (addr_latch) a <= {high_out, mid_out, addr_low};
		wc <= access_n ? 4'h0 : wc + {3'h0, !ready_n};
		if (drv) begin
			lh <= hv;
			lm <= mv;
		end
		if (!access_n && !read_write && ready_n) begin
			wr_n <= wr_n + 1;
			if (width_8 || !a[0]) mem[a] = high_out;
			if (!width_8 && !upper_lane_enable_n) mem[{a[23:1], 1'b1}] = mid_out;
		end
	end
endmodule

// File: dv/external_bus_and_memory_map_tb_top.sv
// self-checking bench of the external bus block
`timescale 1ns/10ps
module external_bus_and_memory_map_tb_top;
	logic CLK, RST, REQ, REQ_WRITE, REQ_WORD, REQ_DONE, REQ_IN_WINDOW, REQ_VECTOR, REQ_SFR, SFR_WRITE;
	logic BUS_WIDTH_8, READY_N, HOLD_REQ_N, BUS_RELEASE_GRANT, CLK_HALF, ACCESS_N, ADDR_LATCH;
	logic READ_WRITE, UPPER_LANE_ENABLE_N, MID_OE, HIGH_OE;
	logic [23:0] REQ_ADDR;
	logic [15:0] REQ_WDATA, DIRECT_WINDOW_BASE, REQ_RDATA, SFR_WDATA, SFR_RDATA;
	logic [7:0] SFR_ADDR, ADDR_LOW, MID_IN, MID_OUT, HIGH_IN, HIGH_OUT, sfr_a;
	logic [3:0] waits;
	logic [16:0] sfr_w;
	logic ule;
	int fail_count = 0, checks = 0, cyc = 0, ext_n = 0, e0, i;
	ebm_bus i_ebm_bus (.CLK(CLK), .RST(RST), .REQ(REQ), .REQ_WRITE(REQ_WRITE), .REQ_WORD(REQ_WORD),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .DIRECT_WINDOW_BASE(DIRECT_WINDOW_BASE),
		.REQ_DONE(REQ_DONE), .REQ_RDATA(REQ_RDATA), .REQ_IN_WINDOW(REQ_IN_WINDOW), .REQ_VECTOR(REQ_VECTOR),
		.REQ_SFR(REQ_SFR), .SFR_ADDR(SFR_ADDR), .SFR_WRITE(SFR_WRITE), .SFR_WDATA(SFR_WDATA),
		.SFR_RDATA(SFR_RDATA), .BUS_WIDTH_8(BUS_WIDTH_8), .READY_N(READY_N), .HOLD_REQ_N(HOLD_REQ_N),
		.BUS_RELEASE_GRANT(BUS_RELEASE_GRANT), .CLK_HALF(CLK_HALF), .ACCESS_N(ACCESS_N),
		.ADDR_LATCH(ADDR_LATCH), .READ_WRITE(READ_WRITE), .UPPER_LANE_ENABLE_N(UPPER_LANE_ENABLE_N),
		.ADDR_LOW(ADDR_LOW), .MID_IN(MID_IN), .MID_OUT(MID_OUT), .MID_OE(MID_OE), .HIGH_IN(HIGH_IN),
		.HIGH_OUT(HIGH_OUT), .HIGH_OE(HIGH_OE));
	ebm_ext_mem i_ebm_ext_mem (.clk(CLK), .width_8(BUS_WIDTH_8), .waits(waits), .access_n(ACCESS_N),
		.addr_latch(ADDR_LATCH), .read_write(READ_WRITE), .upper_lane_enable_n(UPPER_LANE_ENABLE_N),
		.addr_low(ADDR_LOW), .mid_out(MID_OUT), .high_out(HIGH_OUT), .mid_in(MID_IN), .high_in(HIGH_IN),
		.ready_n(READY_N));
	// ----
	// clock, watch and timeout
	// ----
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (!ACCESS_N) begin
			ext_n++;
			ule = UPPER_LANE_ENABLE_N;
		end
		if (REQ_SFR) begin
			sfr_a = SFR_ADDR;
			sfr_w = {SFR_WRITE, SFR_WDATA};
		end
		if (cyc == 20000) begin
			fail_count++;
			complete_run;
		end
	end
	// ----
	// shared tasks
	// ----
	task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
		checks++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic acc(input logic w, input logic wd, input logic [23:0] ad, input logic [15:0] d);
		int n;
		REQ = 1'b1;
		REQ_WRITE = w;
		REQ_WORD = wd;
		REQ_ADDR = ad;
		REQ_WDATA = d;
		for (n = 0; n < 40; n++) begin
			@(posedge CLK);
			#1;
			if (REQ_DONE === 1'b1) break;
		end
		REQ = 1'b0;
		chk("done", 24'h1, {23'h0, REQ_DONE});
		// one idle edge, so back-to-back requests show a gap
		@(posedge CLK);
		#1;
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task t_ext(input logic w8, input logic [23:0] ad);
		BUS_WIDTH_8 = w8;
		waits = 4'h0;
		acc(1'b1, 1'b1, ad, 16'hC35A);
		chk("lo byte", 24'hC35A & 24'hFF, {16'h0, i_ebm_ext_mem.mem[ad]});
		chk("hi byte", 24'hC3, {16'h0, i_ebm_ext_mem.mem[ad + 24'h1]});
		waits = 4'h3;
		acc(1'b0, 1'b1, ad, 16'h0000);
		chk("rdata", 24'hC35A, {8'h0, REQ_RDATA});
		$display("external test done");
	endtask
	task t_lane;
		BUS_WIDTH_8 = 1'b0;
		acc(1'b1, 1'b0, 24'h120461, 16'h0077);
		chk("odd lane", 24'h0, {23'h0, ule});
		acc(1'b1, 1'b0, 24'h120460, 16'h0077);
		chk("even lane", 24'h1, {23'h0, ule});
		$display("lane test done");
	endtask
	task t_map;
		e0 = ext_n;
		acc(1'b1, 1'b1, 24'h000080, 16'hBEEF);
		acc(1'b1, 1'b1, 24'h00087E, 16'h1357);
		acc(1'b0, 1'b1, 24'h000080, 16'h0000);
		chk("ram low", 24'hBEEF, {8'h0, REQ_RDATA});
		acc(1'b0, 1'b1, 24'h00087E, 16'h0000);
		chk("ram top", 24'h1357, {8'h0, REQ_RDATA});
		acc(1'b0, 1'b0, 24'h00007F, 16'h0000);
		chk("reg addr", 24'h7F, {16'h0, sfr_a});
		chk("reg data", 24'h5AA5, {8'h0, REQ_RDATA});
		acc(1'b1, 1'b1, 24'h000040, 16'hA55A);
		chk("reg write", 24'h1A55A, {7'h0, sfr_w});
		chk("no strobe", 24'(e0), 24'(ext_n));
		acc(1'b1, 1'b1, 24'h010080, 16'h2468);
		chk("bank one", 24'h68, {16'h0, i_ebm_ext_mem.mem[24'h010080]});
		acc(1'b1, 1'b0, 24'h000880, 16'h0099);
		chk("past ram", 24'h99, {16'h0, i_ebm_ext_mem.mem[24'h000880]});
		$display("map test done");
	endtask
	task t_flags;
		logic [23:0] ta [6];
		logic [1:0] te [6];
		ta = '{24'h001000, 24'h0010FF, 24'h001100, 24'h00FFD6, 24'h00FFD5, 24'h01FFD6};
		te = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b00, 2'b00};
		DIRECT_WINDOW_BASE = 16'h1000;
		for (i = 0; i < 6; i++) begin
			acc(1'b0, 1'b0, ta[i], 16'h0000);
			chk("flags", {22'h0, te[i]}, {22'h0, REQ_IN_WINDOW, REQ_VECTOR});
		end
		$display("flag test done");
	endtask
	task t_hold;
		// external master asks for the bus
		HOLD_REQ_N = 1'b0;
		repeat (3) @(posedge CLK);
		#1;
		chk("grant", 24'h1, {23'h0, BUS_RELEASE_GRANT});
		HOLD_REQ_N = 1'b1;
		repeat (2) @(posedge CLK);
		#1;
		chk("release", 24'h0, {23'h0, BUS_RELEASE_GRANT});
		$display("hold test done");
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		{REQ, REQ_WRITE, REQ_WORD, BUS_WIDTH_8} = 4'h0;
		{RST, HOLD_REQ_N} = 2'b11;
		REQ_ADDR = 24'h0;
		REQ_WDATA = 16'h0;
		DIRECT_WINDOW_BASE = 16'h0;
		SFR_RDATA = 16'h5AA5;
		waits = 4'h0;
		repeat (6) @(posedge CLK);
		#1;
		chk("reset pins", 24'h7, {21'h0, ACCESS_N, READ_WRITE, UPPER_LANE_ENABLE_N});
		RST = 1'b0;
		@(posedge CLK);
		#1;
		e0 = CLK_HALF;
		@(posedge CLK);
		#1;
		chk("half clock", {23'h0, !e0[0]}, {23'h0, CLK_HALF});
		t_ext(1'b0, 24'h123456);
		t_ext(1'b1, 24'h009000);
		t_lane;
		t_map;
		t_flags;
		t_hold;
		complete_run;
	end
endmodule
